// [rtl/twc_pkg.sv]
// Purpose: Constants for the 8-bit timer waveform output control block
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes: Offsets are byte addresses
package twc_pkg;
   localparam logic [7:0] ADDR_WAVE_CTRL = 8'h00;
   localparam logic [7:0] ADDR_WAVE_CTRL2 = 8'h04;
   localparam logic [7:0] ADDR_CMP_A = 8'h08;
   localparam logic [7:0] ADDR_CMP_B = 8'h0C;
   localparam logic [7:0] ADDR_COUNT = 8'h10;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
   localparam logic [7:0] ADDR_IRQ_CLR = 8'h18;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h1C;
   localparam logic [7:0] ADDR_PIN_CTRL = 8'h20;
   // Field positions of the waveform control register
   localparam int COM_A_LSB = 6;
   localparam int COM_B_LSB = 4;
   localparam int WGM_LOW_LSB = 0;
   localparam logic [7:0] WAVE_CTRL_WMASK = 8'hF3;
   localparam logic [7:0] WAVE_CTRL_RESET = 8'h00;
   // Status bit positions
   localparam int ST_OVF = 0;
   localparam int ST_MATCH_A = 1;
   localparam int ST_MATCH_B = 2;
   localparam logic [7:0] CNT_MAX = 8'hFF;
   localparam logic [7:0] CNT_BOTTOM = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // Waveform mode codes
   localparam logic [2:0] WM_NORMAL = 3'h0;
   localparam logic [2:0] WM_PC_FF = 3'h1;
   localparam logic [2:0] WM_CTC = 3'h2;
   localparam logic [2:0] WM_FAST_FF = 3'h3;
   localparam logic [2:0] WM_PC_A = 3'h5;
   localparam logic [2:0] WM_FAST_A = 3'h7;
   localparam logic [1:0] COM_OFF = 2'h0;
   localparam logic [1:0] COM_TOGGLE = 2'h1;
   localparam logic [1:0] COM_CLEAR = 2'h2;
   localparam logic [1:0] COM_SET = 2'h3;
endpackage

// [rtl/twc_timer8_wave.sv]
// Purpose: Waveform generation and compare output control of an 8-bit timer
// Assumes: Timer advances one step per enabled clk cycle (no prescaler here)
// Notes: Register access over AXI4-Lite; one level interrupt output
`timescale 1ns/1ps

// Summary of operation
// [R01] A nonzero channel A output mode hands the A pin to the waveform, except value 1 in PWM with top bit clear; driven only if dir is out.
// [R02] Non-PWM channel A modes 0..3 mean disconnect, toggle, clear, set on match.
// [R03] Fast PWM channel A value 2 clears on match and sets at bottom, value 3 the inverse.
// [R04] PWM channel A value 1 stays disconnected unless the top mode bit is set, then toggles.
// [R05] Fast PWM with compare equal to top and high field bit ignores match, acts at bottom only.
// [R06] Phase-correct channel A value 2 clears on up match and sets on down match, 3 reverses.
// [R07] Phase-correct with compare equal to top and high field bit ignores match, acts at top.
// [R08] A nonzero channel B output mode hands the B pin to the waveform, driven only if dir is out.
// [R09] Non-PWM channel B modes 0..3 mean disconnect, toggle, clear, set on match.
// [R10] Fast PWM channel B values 2 and 3 act as for A, and value 1 is reserved in PWM modes.
// [R11] Phase-correct channel B value 2 clears on up match and sets on down match, 3 reverses.
// [R12] Bits 3 and 2 of the waveform control register always read zero.
// [R13] The three-bit mode picks normal, phase-correct, clear-on-match or fast PWM and its top.
// [R14] Compare writes act at once in modes 0 and 2, at top in 1 and 5, at bottom in 3 and 7.
// [R15] Overflow flag sets at max in 0, 2, 3, at bottom in 1 and 5, and at top in mode 7.
// [R16] Phase-correct counting runs up to top then down to bottom, turning at top.
// [R17] Fast PWM counting climbs to top then wraps to zero on the next step.
module twc_timer8_wave #(
   parameter int ADDR_W = 8
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [1:0] port_out_in,
   output logic wave_out_a,
   output logic wave_out_b,
   output logic [1:0] pin_out,
   output logic [1:0] pin_oe,
   output logic irq
);
   if (ADDR_W < 8) begin
      $error("ADDR_W must be at least 8");
   end

   logic [7:0] wave_ctrl_reg;
   logic waveform_mode_top_bit;
   logic [7:0] compare_value_a, compare_value_b;
   logic [7:0] cmp_a_buf, cmp_b_buf;
   logic [7:0] counter_value;
   logic count_down;
   logic [2:0] irq_stat_reg, irq_en_reg, irq_clr;
   logic [1:0] pin_dir_reg;
   logic [1:0] cmp_out_mode_a, cmp_out_mode_b;
   logic [2:0] waveform_mode_sel;
   logic [7:0] top_val;
   logic is_fast, is_pc, is_pwm, at_top, at_bottom, pin_a_owned;
   logic match_a, match_b, ovf_evt;

   // AXI write and read channel state
   logic aw_held, w_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_go;
   logic rd_go;

   assign cmp_out_mode_a = wave_ctrl_reg[twc_pkg::COM_A_LSB +: 2];
   assign cmp_out_mode_b = wave_ctrl_reg[twc_pkg::COM_B_LSB +: 2];
   assign waveform_mode_sel = {waveform_mode_top_bit,
                               wave_ctrl_reg[twc_pkg::WGM_LOW_LSB +: 2]};

   // Mode decode; reserved modes 4 and 6 fall back to free counting
   always_comb begin
      is_fast = 1'b0;
      is_pc = 1'b0;
      top_val = twc_pkg::CNT_MAX;
      case (waveform_mode_sel)
         twc_pkg::WM_PC_FF: is_pc = 1'b1; // R13
         twc_pkg::WM_CTC: top_val = compare_value_a; // R13
         twc_pkg::WM_FAST_FF: is_fast = 1'b1; // R13
         twc_pkg::WM_PC_A: begin
            is_pc = 1'b1; // R13
            top_val = compare_value_a;
         end
         twc_pkg::WM_FAST_A: begin
            is_fast = 1'b1; // R13
            top_val = compare_value_a;
         end
         default: top_val = twc_pkg::CNT_MAX;
      endcase
   end
   assign is_pwm = is_fast | is_pc;
   assign at_top = (counter_value == top_val);
   assign at_bottom = (counter_value == twc_pkg::CNT_BOTTOM);
   assign match_a = (counter_value == compare_value_a);
   assign match_b = (counter_value == compare_value_b);

   always_comb begin
      if (waveform_mode_sel == twc_pkg::WM_FAST_A) begin
         ovf_evt = at_top; // R15
      end else if (is_pc) begin
         ovf_evt = at_bottom && count_down; // R15
      end else begin
         ovf_evt = (counter_value == twc_pkg::CNT_MAX); // R15
      end
   end

   // Next output level of one channel for the current step
   function automatic logic wave_next(input logic cur, input logic [1:0] com,
                                      input logic match, input logic is_a,
                                      input logic top_bit, input logic fast,
                                      input logic pc, input logic down,
                                      input logic cmp_is_top, input logic bot,
                                      input logic top);
      logic r;
      r = cur;
      if (!fast && !pc) begin
         if (match) begin
            case (com)
               twc_pkg::COM_TOGGLE: r = ~cur; // R02 R09
               twc_pkg::COM_CLEAR: r = 1'b0;
               twc_pkg::COM_SET: r = 1'b1;
               default: r = cur;
            endcase
         end
      end else if (com == twc_pkg::COM_TOGGLE) begin
         if (is_a && top_bit && match) begin
            r = ~cur; // R04 R10
         end
      end else if (com[1] && fast) begin
         if (cmp_is_top) begin
            if (bot) r = ~com[0]; // R05
         end else if (match) begin
            r = com[0]; // R03 R10
         end else if (bot) begin
            r = ~com[0];
         end
      end else if (com[1] && pc) begin
         if (cmp_is_top) begin
            if (top) r = ~com[0]; // R07
         end else if (match) begin
            r = down ? ~com[0] : com[0]; // R06 R11
         end
      end
      return r;
   endfunction

   // Counter stepping
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         counter_value <= twc_pkg::CNT_BOTTOM;
         count_down <= 1'b0;
      end else if (clk_en) begin
         if (wr_go && aw_addr[7:0] == twc_pkg::ADDR_COUNT && w_strb[0]) begin
            counter_value <= w_data[7:0];
         end else if (is_pc) begin
            if (!count_down && at_top) begin
               count_down <= 1'b1; // R16
               counter_value <= counter_value - 8'h01;
            end else if (count_down && at_bottom) begin
               count_down <= 1'b0;
               counter_value <= counter_value + 8'h01;
            end else if (count_down) begin
               counter_value <= counter_value - 8'h01;
            end else begin
               counter_value <= counter_value + 8'h01;
            end
         end else begin
            count_down <= 1'b0;
            counter_value <= at_top ? twc_pkg::CNT_BOTTOM : counter_value + 8'h01; // R17
         end
      end
   end

   // Compare buffers; live values reload per mode
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         compare_value_a <= twc_pkg::CNT_BOTTOM;
         compare_value_b <= twc_pkg::CNT_BOTTOM;
      end else if (clk_en) begin
         if (!is_pwm || (is_pc && at_top) || (is_fast && at_top)) begin
            compare_value_a <= cmp_a_buf; // R14
            compare_value_b <= cmp_b_buf; // R14
         end
      end
   end

   // Waveform outputs
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wave_out_a <= 1'b0;
         wave_out_b <= 1'b0;
      end else if (clk_en) begin
         wave_out_a <= wave_next(wave_out_a, cmp_out_mode_a, match_a, 1'b1,
                                 waveform_mode_top_bit, is_fast, is_pc, count_down,
                                 compare_value_a == top_val,
                                 at_top && is_fast, at_top && !count_down);
         wave_out_b <= wave_next(wave_out_b, cmp_out_mode_b, match_b, 1'b0,
                                 waveform_mode_top_bit, is_fast, is_pc, count_down,
                                 compare_value_b == top_val,
                                 at_top && is_fast, at_top && !count_down);
      end
   end

   // Pin mux: A in PWM with value 1 and top bit clear stays with the port
   assign pin_a_owned = (cmp_out_mode_a != twc_pkg::COM_OFF) &&
                        !(is_pwm && !waveform_mode_top_bit &&
                          cmp_out_mode_a == twc_pkg::COM_TOGGLE); // R01 R04
   always_comb begin
      pin_out[0] = pin_a_owned ? wave_out_a : port_out_in[0]; // R01
      pin_out[1] = (cmp_out_mode_b != twc_pkg::COM_OFF) ? wave_out_b : port_out_in[1]; // R08
      pin_oe = pin_dir_reg; // R01 R08
   end

   // Sticky events; a set in the clear cycle wins
   assign irq_clr = (wr_go && aw_addr[7:0] == twc_pkg::ADDR_IRQ_CLR && w_strb[0]) ?
                    w_data[2:0] : 3'h0;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_stat_reg <= 3'h0;
      end else if (clk_en) begin
         irq_stat_reg <= (irq_stat_reg & ~irq_clr) |
                         {match_b, match_a, ovf_evt}; // R15
      end
   end
   assign irq = |(irq_stat_reg & irq_en_reg);

   // Write path, either order; readies drop with clk_en so no handshake is lost
   assign s_axi_awready = clk_en && !aw_held && !s_axi_bvalid;
   assign s_axi_wready = clk_en && !w_held && !s_axi_bvalid;
   assign wr_go = aw_held && w_held && !s_axi_bvalid;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= twc_pkg::RESP_OKAY;
      end else if (clk_en) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr[7:0] > twc_pkg::ADDR_PIN_CTRL || aw_addr[1:0] != 2'b00)
                           ? twc_pkg::RESP_SLVERR : twc_pkg::RESP_OKAY;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Register writes
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wave_ctrl_reg <= twc_pkg::WAVE_CTRL_RESET;
         waveform_mode_top_bit <= 1'b0;
         cmp_a_buf <= twc_pkg::CNT_BOTTOM;
         cmp_b_buf <= twc_pkg::CNT_BOTTOM;
         irq_en_reg <= 3'h0;
         pin_dir_reg <= 2'h0;
      end else if (clk_en && wr_go && w_strb[0]) begin
         if (aw_addr[7:0] == twc_pkg::ADDR_WAVE_CTRL) begin
            wave_ctrl_reg <= w_data[7:0] & twc_pkg::WAVE_CTRL_WMASK; // R12
         end else if (aw_addr[7:0] == twc_pkg::ADDR_WAVE_CTRL2) begin
            waveform_mode_top_bit <= w_data[0];
         end else if (aw_addr[7:0] == twc_pkg::ADDR_CMP_A) begin
            cmp_a_buf <= w_data[7:0];
         end else if (aw_addr[7:0] == twc_pkg::ADDR_CMP_B) begin
            cmp_b_buf <= w_data[7:0];
         end else if (aw_addr[7:0] == twc_pkg::ADDR_IRQ_EN) begin
            irq_en_reg <= w_data[2:0];
         end else if (aw_addr[7:0] == twc_pkg::ADDR_PIN_CTRL) begin
            pin_dir_reg <= w_data[1:0];
         end
      end
   end

   // AXI4-Lite read path
   assign s_axi_arready = clk_en && !s_axi_rvalid;
   assign rd_go = s_axi_arvalid && s_axi_arready;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= twc_pkg::RESP_OKAY;
      end else if (clk_en) begin
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= twc_pkg::RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            if (s_axi_araddr[7:0] == twc_pkg::ADDR_WAVE_CTRL) begin
               s_axi_rdata[7:0] <= wave_ctrl_reg & twc_pkg::WAVE_CTRL_WMASK; // R12
            end else if (s_axi_araddr[7:0] == twc_pkg::ADDR_WAVE_CTRL2) begin
               s_axi_rdata[0] <= waveform_mode_top_bit;
            end else if (s_axi_araddr[7:0] == twc_pkg::ADDR_CMP_A) begin
               s_axi_rdata[7:0] <= cmp_a_buf;
            end else if (s_axi_araddr[7:0] == twc_pkg::ADDR_CMP_B) begin
               s_axi_rdata[7:0] <= cmp_b_buf;
            end else if (s_axi_araddr[7:0] == twc_pkg::ADDR_COUNT) begin
               s_axi_rdata[7:0] <= counter_value;
            end else if (s_axi_araddr[7:0] == twc_pkg::ADDR_IRQ_STAT) begin
               s_axi_rdata[2:0] <= irq_stat_reg;
            end else if (s_axi_araddr[7:0] == twc_pkg::ADDR_IRQ_EN) begin
               s_axi_rdata[2:0] <= irq_en_reg;
            end else if (s_axi_araddr[7:0] == twc_pkg::ADDR_PIN_CTRL) begin
               s_axi_rdata[1:0] <= pin_dir_reg;
            end else if (s_axi_araddr[7:0] != twc_pkg::ADDR_IRQ_CLR) begin
               s_axi_rresp <= twc_pkg::RESP_SLVERR;
            end
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Checks
   a_ctrl_reserved_zero: assert property (@(posedge clk) disable iff (!rst_b) // R12
      wave_ctrl_reg[3:2] == 2'b00) else $error("reserved control bits set");
   a_pin_a_mux: assert property (@(posedge clk) disable iff (!rst_b) // R01
      cmp_out_mode_a != 2'h0 && !(is_pwm && cmp_out_mode_a == 2'h1 && !waveform_mode_top_bit)
      |-> pin_out[0] == wave_out_a) else $error("pin A not waveform");
   a_pin_a_port: assert property (@(posedge clk) disable iff (!rst_b) // R04
      is_pwm && cmp_out_mode_a == 2'h1 && !waveform_mode_top_bit
      |-> pin_out[0] == port_out_in[0]) else $error("pin A not released to port");
   a_pin_b_mux: assert property (@(posedge clk) disable iff (!rst_b) // R08
      cmp_out_mode_b != 2'h0 |-> pin_out[1] == wave_out_b) else $error("pin B not waveform");
   a_fast_wrap: assert property (@(posedge clk) disable iff (!rst_b) // R17
      clk_en && is_fast && at_top && !wr_go ##1 clk_en |-> counter_value == 8'h00)
      else $error("fast PWM did not wrap");
   a_pc_turn: assert property (@(posedge clk) disable iff (!rst_b) // R16
      clk_en && is_pc && at_top && !count_down && !wr_go && counter_value != 8'h00
      |=> count_down) else $error("phase-correct did not turn");
   a_ovf_sticky: assert property (@(posedge clk) disable iff (!rst_b) // R15
      clk_en && ovf_evt |=> irq_stat_reg[0]) else $error("overflow not flagged");
   a_normal_clear: assert property (@(posedge clk) disable iff (!rst_b) // R02
      clk_en && !is_pwm && match_a && cmp_out_mode_a == 2'h2 |=> !wave_out_a)
      else $error("A not cleared on match");
   a_normal_set_b: assert property (@(posedge clk) disable iff (!rst_b) // R09
      clk_en && !is_pwm && match_b && cmp_out_mode_b == 2'h3 |=> wave_out_b)
      else $error("B not set on match");
   a_b_tog_reserved: assert property (@(posedge clk) disable iff (!rst_b) // R10
      clk_en && is_pwm && cmp_out_mode_b == 2'h1 |=> $stable(wave_out_b))
      else $error("B changed in reserved mode");
endmodule

// [bench/twc_timer8_wave_tb_top.sv]
// Purpose: Self-checking bench for the timer waveform output control block
// Assumes: One clock at 250 MHz, AXI4-Lite master driven from this bench
// Notes: Duty is counted over whole periods so output latency cannot skew it
`timescale 1ns/1ps
module twc_timer8_wave_tb_top;
   typedef struct {
      logic [7:0] ctrl; logic top; logic [7:0] ca; logic [7:0] cb; int len;
      logic [1:0] conn; logic [1:0] cw; int ha; int hb;
   } twc_row_t;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic clk_en = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid, wave_a, wave_b, irq;
   logic [1:0] bresp, rresp, pin_out, pin_oe;
   logic [1:0] port_in = 2'b10;
   logic [31:0] rdata, rd;
   logic [1:0] rsp;
   int n_fail = 0;
   int n_compared = 0;
   int ha, hb, bad, k;
   twc_row_t rows [11];
   logic [7:0] radr [6];

   always #2 clk = ~clk;

   twc_timer8_wave #(.ADDR_W(8)) twc_timer8_wave_i (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .port_out_in(port_in), .wave_out_a(wave_a), .wave_out_b(wave_b), .pin_out(pin_out),
      .pin_oe(pin_oe), .irq(irq));

   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task test_done();
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Handshakes are judged at rising edges; every input moves just after one
   task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic tb;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      tb = 1'b0;
      while (!tb) begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            r = bresp;
            bready <= 1'b0;
            tb = 1'b1;
         end
      end
   endtask

   task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic tr;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      tr = 1'b0;
      while (!tr) begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            tr = 1'b1;
         end
      end
   endtask

   // Counts high cycles and checks pin muxing and drive enable each cycle
   task measure(input int len, input logic [1:0] conn);
      ha = 0;
      hb = 0;
      bad = 0;
      repeat (len) begin
         @(negedge clk);
         ha += int'(wave_a);
         hb += int'(wave_b);
         if (pin_out[0] !== (conn[0] ? wave_a : port_in[0])) bad++;
         if (pin_out[1] !== (conn[1] ? wave_b : port_in[1])) bad++;
         if (pin_oe !== 2'b11) bad++;
      end
   endtask

   // The tests need about 18k cycles; 50k cycles leaves a wide margin
   initial begin
      #200000;
      n_fail++;
      test_done();
   end

   initial begin
      rows[0] = '{8'h50, 1'b0, 8'h20, 8'h20, 512, 2'b11, 2'b11, 256, 256};
      rows[1] = '{8'hB0, 1'b0, 8'h20, 8'h20, 512, 2'b11, 2'b11, 0, 512};
      rows[2] = '{8'h00, 1'b0, 8'h20, 8'h20, 64, 2'b00, 2'b00, 0, 0};
      rows[3] = '{8'h52, 1'b0, 8'h3F, 8'h10, 128, 2'b11, 2'b11, 64, 64};
      rows[4] = '{8'hB3, 1'b0, 8'h40, 8'h40, 256, 2'b11, 2'b11, 65, 191};
      rows[5] = '{8'hE3, 1'b0, 8'hFF, 8'h00, 256, 2'b11, 2'b11, 0, 1};
      rows[6] = '{8'hB1, 1'b0, 8'h40, 8'h40, 510, 2'b11, 2'b11, 128, 382};
      rows[7] = '{8'hE1, 1'b0, 8'h10, 8'hFF, 510, 2'b11, 2'b11, 478, 510};
      rows[8] = '{8'h61, 1'b0, 8'h20, 8'h40, 510, 2'b10, 2'b10, 0, 128};
      rows[9] = '{8'h63, 1'b1, 8'h3F, 8'h10, 128, 2'b11, 2'b11, 64, 34};
      rows[10] = '{8'h71, 1'b1, 8'h3F, 8'h10, 252, 2'b11, 2'b11, 126, 188};
      radr = '{twc_pkg::ADDR_WAVE_CTRL, twc_pkg::ADDR_WAVE_CTRL2, twc_pkg::ADDR_CMP_A,
               twc_pkg::ADDR_CMP_B, twc_pkg::ADDR_IRQ_EN, twc_pkg::ADDR_PIN_CTRL};
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      foreach (radr[i]) begin
         axi_rd(radr[i], rd, rsp);
         check(rd, 32'h0000_0000);
         check(rsp, twc_pkg::RESP_OKAY);
      end
      check(pin_oe, 2'b00);
      check(irq, 1'b0);
      axi_wr(twc_pkg::ADDR_PIN_CTRL, 32'h0000_0003, rsp);
      foreach (rows[i]) begin
         port_in <= i[1:0];
         axi_wr(twc_pkg::ADDR_WAVE_CTRL2, {31'h0, rows[i].top}, rsp);
         axi_wr(twc_pkg::ADDR_CMP_A, {24'h0, rows[i].ca}, rsp);
         axi_wr(twc_pkg::ADDR_CMP_B, {24'h0, rows[i].cb}, rsp);
         axi_wr(twc_pkg::ADDR_WAVE_CTRL, {24'h0, rows[i].ctrl}, rsp);
         repeat (1100) @(posedge clk);
         measure(rows[i].len, rows[i].conn);
         check(bad, 0);
         if (rows[i].cw[0]) check(ha, rows[i].ha);
         if (rows[i].cw[1]) check(hb, rows[i].hb);
      end
      // Reserved bits read back as zero whatever is written
      axi_wr(twc_pkg::ADDR_WAVE_CTRL, 32'h0000_00FF, rsp);
      axi_rd(twc_pkg::ADDR_WAVE_CTRL, rd, rsp);
      check(rd, 32'h0000_00F3);
      axi_rd(8'h40, rd, rsp);
      check(rsp, twc_pkg::RESP_SLVERR);
      axi_wr(8'h40, 32'h0000_0001, rsp);
      check(rsp, twc_pkg::RESP_SLVERR);
      // Overflow source per mode: fast with top from A, clear-on-match, normal
      axi_wr(twc_pkg::ADDR_CMP_A, 32'h0000_003F, rsp);
      for (k = 0; k < 3; k++) begin
         axi_wr(twc_pkg::ADDR_WAVE_CTRL2, (k == 0) ? 32'h1 : 32'h0, rsp);
         axi_wr(twc_pkg::ADDR_WAVE_CTRL, (k == 0) ? 32'h3 : ((k == 1) ? 32'h2 : 32'h0), rsp);
         repeat (300) @(posedge clk);
         axi_wr(twc_pkg::ADDR_IRQ_CLR, 32'h0000_0007, rsp);
         repeat (300) @(posedge clk);
         axi_rd(twc_pkg::ADDR_IRQ_STAT, rd, rsp);
         check(rd & 32'h1, (k == 1) ? 32'h0 : 32'h1);
      end
      // Interrupt raised, cleared, then masked
      axi_wr(twc_pkg::ADDR_IRQ_CLR, 32'h0000_0007, rsp);
      axi_wr(twc_pkg::ADDR_IRQ_EN, 32'h0000_0001, rsp);
      k = 0;
      while (irq !== 1'b1 && k < 600) begin
         @(posedge clk);
         k++;
      end
      check(irq, 1'b1);
      axi_wr(twc_pkg::ADDR_IRQ_CLR, 32'h0000_0001, rsp);
      check(irq, 1'b0);
      axi_wr(twc_pkg::ADDR_IRQ_EN, 32'h0000_0000, rsp);
      check(irq, 1'b0);
      repeat (300) @(posedge clk);
      check(irq, 1'b0);
      axi_rd(twc_pkg::ADDR_IRQ_STAT, rd, rsp);
      check(rd & 32'h1, 32'h1);
      test_done();
   end
endmodule
